// file: csac_pkg.sv
// Shared types and constants for the store, atomic and trap-return capability checker
package csac_pkg;

   // ----------------------------------------------------------------
   // Widths and geometry
   // ----------------------------------------------------------------
   localparam int XLEN      = 64;
   localparam int CAP_WIDTH = 128;
   localparam int CAP_BYTES = CAP_WIDTH / 8;
   localparam int BLK_LSB   = $clog2(CAP_BYTES);
   localparam int OFF_W     = 12;
   localparam int LEN_W     = 5;
   localparam int BE_W      = 8;
   localparam int BE_LSB    = $clog2(BE_W);

   localparam logic [XLEN-1:0] ADDR32_MASK = 64'h0000_0000_ffff_ffff;
   localparam logic [XLEN-1:0] ADDR64_MASK = 64'hffff_ffff_ffff_ffff;

   // ----------------------------------------------------------------
   // Trap codes and fault type/cause fields
   // ----------------------------------------------------------------
   localparam logic [4:0] EXC_ILLEGAL     = 5'h02;
   localparam logic [4:0] EXC_LD_MISALIGN = 5'h04;
   localparam logic [4:0] EXC_LD_ACCESS   = 5'h05;
   localparam logic [4:0] EXC_ST_MISALIGN = 5'h06;
   localparam logic [4:0] EXC_ST_ACCESS   = 5'h07;
   localparam logic [4:0] EXC_CAP_FAULT   = 5'h1c;

   localparam logic [3:0] TYPE_NONE       = 4'h0;
   localparam logic [3:0] TYPE_INSTR      = 4'h1;
   localparam logic [3:0] TYPE_DATA       = 4'h2;

   localparam logic [4:0] CAUSE_NONE      = 5'h00;
   localparam logic [4:0] CAUSE_TAG       = 5'h01;
   localparam logic [4:0] CAUSE_SEAL      = 5'h02;
   localparam logic [4:0] CAUSE_PERM      = 5'h03;
   localparam logic [4:0] CAUSE_LEN       = 5'h04;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {OP_NONE, OP_STORE, OP_AMO, OP_AMOSWAP_C, OP_LR, OP_MRET, OP_SRET,
                             OP_DRET} csac_op_e;
   typedef enum logic [1:0] {SZ_B, SZ_H, SZ_W, SZ_D} csac_size_e;

   typedef struct packed {
      logic rd;
      logic wr;
      logic cap;
      logic sysreg_access_perm;
      logic ex;
   } csac_perm_s;

   typedef struct packed {
      logic              tag;
      logic              sealed;
      csac_perm_s        perm;
      logic [XLEN-1:0]   base;
      logic [XLEN:0]     top;
      logic [XLEN-1:0]   addr;
   } csac_cap_s;

   typedef struct packed {
      logic              valid;
      csac_op_e          op;
      csac_size_e        size;
      logic              cap_mode;
      logic [XLEN-1:0]   int_base;
      csac_cap_s         cap_base_reg;
      logic [OFF_W-1:0]  offset;
      logic [XLEN-1:0]   wdata;
      logic              src_tag;
   } csac_req_s;

   typedef struct packed {
      logic rv64;
      logic purecap;
      logic legacy;
      logic ext_a;
      logic zam;
      logic zabhlrsc;
      logic sdext;
   } csac_cfg_s;

   typedef struct packed {
      logic              done;
      logic              trap;
      logic [4:0]        exc_code;
      logic [3:0]        tval_type;
      logic [4:0]        tval_cause;
   } csac_resp_s;

   typedef struct packed {
      logic              valid;
      logic              write;
      logic              read;
      logic [XLEN-1:0]   addr;
      logic [XLEN-1:0]   wdata;
      logic [BE_W-1:0]   be;
      logic              tag_clr;
      logic [XLEN-1:0]   tag_clr_addr;
      logic              tag_clr_two;
      logic              tag_wr;
      logic              tag_wr_val;
   } csac_mem_s;

endpackage : csac_pkg

// file: csac_bounds.sv
// Bounds check of an access range against a capability
`timescale 1ns/1ps
module csac_bounds
(
   input  wire csac_pkg::csac_cap_s              cap_i,
   input  wire logic [csac_pkg::XLEN-1:0]        addr_i,
   input  wire logic [csac_pkg::LEN_W-1:0]       len_i,
   output logic                                  in_bounds_o
);

   logic [csac_pkg::XLEN:0] end_addr;

   // Extra top bit keeps an access ending at the address ceiling from wrapping
   always_comb
   begin
      end_addr    = {1'b0, addr_i} + {{(csac_pkg::XLEN+1-csac_pkg::LEN_W){1'b0}}, len_i};
      in_bounds_o = (addr_i >= cap_i.base) && (end_addr <= cap_i.top);
   end

endmodule : csac_bounds

// file: csac_tag_clr.sv
// Capability-sized blocks touched by an integer store
`timescale 1ns/1ps
module csac_tag_clr
(
   input  wire logic [csac_pkg::XLEN-1:0]        addr_i,
   input  wire logic [csac_pkg::LEN_W-1:0]       len_i,
   output logic      [csac_pkg::XLEN-1:0]        blk_addr_o,
   output logic                                  two_blk_o
);

   logic [csac_pkg::XLEN-1:0] last_byte;

   // A misaligned store may straddle two blocks; both lose their tags
   always_comb
   begin
      last_byte  = addr_i + {{(csac_pkg::XLEN-csac_pkg::LEN_W){1'b0}}, len_i}
                   - {{(csac_pkg::XLEN-1){1'b0}}, 1'b1};
      blk_addr_o = {addr_i[csac_pkg::XLEN-1:csac_pkg::BLK_LSB], {csac_pkg::BLK_LSB{1'b0}}};
      two_blk_o  = last_byte[csac_pkg::XLEN-1:csac_pkg::BLK_LSB]
                   != addr_i[csac_pkg::XLEN-1:csac_pkg::BLK_LSB];
   end

endmodule : csac_tag_clr

// file: csac_core.sv
// Capability checks for stores, atomics, load-reserved and trap/debug return
//
// What this block does
// [R1] Capability mode: base cap address plus offset
// [R2] Legacy mode: integer base plus offset, default cap
// [R3] Store writes data, clears touched block tags
// [R4] Store checks tag, seal, write, bounds
// [R5] Check failure reports data fault type, cause
// [R6] Doubleword store only on 64-bit; extension per mode
// [R7] Trap return unseals saved cap into pcc
// [R8] Trap return needs sysreg permission on pcc
// [R9] Debug return unseals debug cap into pcc
// [R10] Debug return never raises capability fault
// [R11] Atomics need read and write permission
// [R12] Atomics fault unless fully within bounds
// [R13] Misaligned atomic: misaligned if Zam, else access
// [R14] Capability swap needs tagged unsealed authority
// [R15] No cap-store permission: swap clears both tags
// [R16] Load-reserved checks tag, seal, read, bounds
// [R17] Misaligned load-reserved: misaligned if Zam, else access
// [R18] Load-reserved sizes need their extensions
// [R19] One cause: tag, seal, permission, length order
`timescale 1ns/1ps
module csac_core
(
   input  wire logic                             clk_sys_i,
   input  wire logic                             arst_n_i,
   input  wire logic                             ce_i,
   input  wire csac_pkg::csac_cfg_s              cfg_i,
   input  wire csac_pkg::csac_req_s              req_i,
   input  wire csac_pkg::csac_cap_s              ddc_i,
   input  wire csac_pkg::csac_cap_s              pcc_i,
   input  wire csac_pkg::csac_cap_s              mepcc_i,
   input  wire csac_pkg::csac_cap_s              sepcc_i,
   input  wire csac_pkg::csac_cap_s              dpcc_i,
   input  wire logic                             swap_ld_valid_i,
   input  wire logic                             swap_ld_tag_i,
   output logic                                  req_ready_o,
   output csac_pkg::csac_resp_s                  resp_o,
   output csac_pkg::csac_mem_s                   mem_o,
   output logic                                  pcc_wr_o,
   output csac_pkg::csac_cap_s                   pcc_o,
   output logic                                  cap_dest_valid_o,
   output logic                                  cap_dest_tag_o
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef enum logic [0:0] {ST_IDLE, ST_SWAP_WAIT} csac_fsm_e;

   typedef struct packed {
      csac_fsm_e            fsm;
      logic                 ready;
      csac_pkg::csac_resp_s resp;
      csac_pkg::csac_mem_s  mem;
      logic                 pcc_wr;
      csac_pkg::csac_cap_s  pcc;
      logic                 swap_cap_perm;
      logic                 dest_valid;
      logic                 dest_tag;
   } csac_state_s;

   csac_state_s st_r;
   csac_state_s st_nxt;

   // ----------------------------------------------------------------
   // Address, authority and access size
   // ----------------------------------------------------------------
   logic [csac_pkg::XLEN-1:0]   off_sext;
   logic [csac_pkg::XLEN-1:0]   eff_raw;
   logic [csac_pkg::XLEN-1:0]   eff_addr;
   csac_pkg::csac_cap_s         auth;
   logic [csac_pkg::LEN_W-1:0]  acc_len;
   logic                        in_bounds;
   logic [csac_pkg::XLEN-1:0]   blk_addr;
   logic                        two_blk;
   logic [csac_pkg::BE_W-1:0]   be_mask;
   logic [csac_pkg::BE_LSB:0]   be_lo;
   logic [csac_pkg::BE_LSB+1:0] be_hi;

   always_comb
   begin
      off_sext = {{(csac_pkg::XLEN-csac_pkg::OFF_W){req_i.offset[csac_pkg::OFF_W-1]}},
                  req_i.offset};
      // [R1] capability-mode address
      // [R2] legacy-mode address
      eff_raw  = req_i.cap_mode ? (req_i.cap_base_reg.addr + off_sext)
                                : (req_i.int_base + off_sext);
      eff_addr = eff_raw & (cfg_i.rv64 ? csac_pkg::ADDR64_MASK : csac_pkg::ADDR32_MASK);
      // [R1] base capability authorises
      // [R2] default data capability authorises
      auth     = req_i.cap_mode ? req_i.cap_base_reg : ddc_i;
      if (req_i.op == csac_pkg::OP_AMOSWAP_C)
         acc_len = csac_pkg::LEN_W'(csac_pkg::CAP_BYTES);
      else
         acc_len = csac_pkg::LEN_W'(5'h01 << req_i.size);
      be_lo    = {1'b0, eff_addr[csac_pkg::BE_LSB-1:0]};
      be_hi    = {1'b0, be_lo} + acc_len[csac_pkg::BE_LSB+1:0];
   end

   // Lanes beyond the word are dropped from the mask; mem_o carries no lanes for the next word
   genvar gi;
   generate
      for (gi = 0; gi < csac_pkg::BE_W; gi++)
      begin : g_be
         assign be_mask[gi] = (gi >= be_lo) && (gi < be_hi);
      end
   endgenerate

   csac_bounds u_bounds
   (
      .cap_i       (auth),
      .addr_i      (eff_addr),
      .len_i       (acc_len),
      .in_bounds_o (in_bounds)
   );

   csac_tag_clr u_tag_clr
   (
      .addr_i      (eff_addr),
      .len_i       (acc_len),
      .blk_addr_o  (blk_addr),
      .two_blk_o   (two_blk)
   );

   // ----------------------------------------------------------------
   // Legality, alignment and capability checks
   // ----------------------------------------------------------------
   logic       mode_ok;
   logic       legal;
   logic       misaligned;
   logic       need_rd;
   logic       need_wr;
   logic       is_data;
   logic       is_ldres;
   logic [4:0] cap_cause;

   always_comb
   begin
      mode_ok    = req_i.cap_mode ? cfg_i.purecap : cfg_i.legacy;
      legal      = 1'b0;
      need_rd    = 1'b0;
      need_wr    = 1'b0;
      is_data    = 1'b1;
      is_ldres   = 1'b0;
      case (req_i.op)
         csac_pkg::OP_STORE:
         begin
            // [R6] doubleword needs 64-bit
            legal   = mode_ok && ((req_i.size != csac_pkg::SZ_D) || cfg_i.rv64);
            need_wr = 1'b1;
         end
         csac_pkg::OP_AMO:
         begin
            // [R11] word or doubleword atomics
            legal   = mode_ok && cfg_i.ext_a &&
                      ((req_i.size == csac_pkg::SZ_W) ||
                       ((req_i.size == csac_pkg::SZ_D) && cfg_i.rv64));
            need_rd = 1'b1;
            need_wr = 1'b1;
         end
         csac_pkg::OP_AMOSWAP_C:
         begin
            legal   = mode_ok && cfg_i.ext_a;
            need_rd = 1'b1;
            need_wr = 1'b1;
         end
         csac_pkg::OP_LR:
         begin
            is_ldres = 1'b1;
            need_rd  = 1'b1;
            // [R18] size prerequisites
            case (req_i.size)
               csac_pkg::SZ_B,
               csac_pkg::SZ_H: legal = mode_ok && cfg_i.zabhlrsc;
               csac_pkg::SZ_W: legal = mode_ok && cfg_i.ext_a;
               default:        legal = mode_ok && cfg_i.ext_a && cfg_i.rv64;
            endcase
         end
         csac_pkg::OP_MRET,
         csac_pkg::OP_SRET:
         begin
            legal   = 1'b1;
            is_data = 1'b0;
         end
         csac_pkg::OP_DRET:
         begin
            legal   = cfg_i.sdext;
            is_data = 1'b0;
         end
         default:
         begin
            legal   = 1'b0;
            is_data = 1'b0;
         end
      endcase
      misaligned = |(eff_addr[csac_pkg::LEN_W-1:0] & (acc_len - csac_pkg::LEN_W'(1)));
      // [R4] store authority checks
      // [R14] swap needs tag and no seal
      // [R16] load-reserved authority checks
      // [R19] single cause by priority
      if (!auth.tag)
         cap_cause = csac_pkg::CAUSE_TAG;
      else if (auth.sealed)
         cap_cause = csac_pkg::CAUSE_SEAL;
      // [R11] read and write permission
      else if ((need_rd && !auth.perm.rd) || (need_wr && !auth.perm.wr))
         cap_cause = csac_pkg::CAUSE_PERM;
      // [R12] whole access within bounds
      else if (!in_bounds)
         cap_cause = csac_pkg::CAUSE_LEN;
      else
         cap_cause = csac_pkg::CAUSE_NONE;
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      st_nxt            = st_r;
      st_nxt.resp       = '0;
      st_nxt.mem.valid  = 1'b0;
      st_nxt.mem.write  = 1'b0;
      st_nxt.mem.read   = 1'b0;
      st_nxt.mem.tag_clr = 1'b0;
      st_nxt.mem.tag_wr = 1'b0;
      st_nxt.pcc_wr     = 1'b0;
      st_nxt.dest_valid = 1'b0;
      case (st_r.fsm)
         ST_IDLE:
         begin
            st_nxt.ready = 1'b1;
            if (req_i.valid && st_r.ready)
            begin
               st_nxt.resp.done = 1'b1;
               if (!legal)
               begin
                  st_nxt.resp.trap     = 1'b1;
                  st_nxt.resp.exc_code = csac_pkg::EXC_ILLEGAL;
               end
               else if (!is_data)
               begin
                  if ((req_i.op == csac_pkg::OP_DRET) || pcc_i.perm.sysreg_access_perm)
                  begin
                     // [R7] unseal saved cap into pcc
                     // [R9] unseal debug cap into pcc
                     // [R10] no permission check on debug return
                     st_nxt.pcc_wr     = 1'b1;
                     st_nxt.pcc        = (req_i.op == csac_pkg::OP_MRET) ? mepcc_i :
                                         (req_i.op == csac_pkg::OP_SRET) ? sepcc_i : dpcc_i;
                     st_nxt.pcc.sealed = 1'b0;
                  end
                  else
                  begin
                     // [R8] instruction access permission fault
                     st_nxt.resp.trap       = 1'b1;
                     st_nxt.resp.exc_code   = csac_pkg::EXC_CAP_FAULT;
                     st_nxt.resp.tval_type  = csac_pkg::TYPE_INSTR;
                     st_nxt.resp.tval_cause = csac_pkg::CAUSE_PERM;
                  end
               end
               else if (misaligned && (req_i.op != csac_pkg::OP_STORE))
               begin
                  // [R13] atomic misalignment
                  // [R17] load-reserved misalignment
                  st_nxt.resp.trap = 1'b1;
                  if (is_ldres)
                     st_nxt.resp.exc_code = cfg_i.zam ? csac_pkg::EXC_LD_MISALIGN
                                                      : csac_pkg::EXC_LD_ACCESS;
                  else
                     st_nxt.resp.exc_code = cfg_i.zam ? csac_pkg::EXC_ST_MISALIGN
                                                      : csac_pkg::EXC_ST_ACCESS;
               end
               else if (cap_cause != csac_pkg::CAUSE_NONE)
               begin
                  // [R5] data fault type and cause
                  st_nxt.resp.trap       = 1'b1;
                  st_nxt.resp.exc_code   = csac_pkg::EXC_CAP_FAULT;
                  st_nxt.resp.tval_type  = csac_pkg::TYPE_DATA;
                  st_nxt.resp.tval_cause = cap_cause;
               end
               else
               begin
                  st_nxt.mem.valid = 1'b1;
                  st_nxt.mem.addr  = eff_addr;
                  st_nxt.mem.wdata = req_i.wdata;
                  st_nxt.mem.read  = need_rd;
                  st_nxt.mem.write = need_wr;
                  st_nxt.mem.be    = (req_i.op == csac_pkg::OP_AMOSWAP_C) ? '1 : be_mask;
                  if (req_i.op == csac_pkg::OP_STORE)
                  begin
                     // [R3] clear tags of touched blocks
                     st_nxt.mem.tag_clr      = 1'b1;
                     st_nxt.mem.tag_clr_addr = blk_addr;
                     st_nxt.mem.tag_clr_two  = two_blk;
                  end
                  if (req_i.op == csac_pkg::OP_AMOSWAP_C)
                  begin
                     // [R15] stored tag gated by cap-store permission
                     st_nxt.mem.tag_wr     = 1'b1;
                     st_nxt.mem.tag_wr_val = req_i.src_tag && auth.perm.cap;
                     st_nxt.swap_cap_perm  = auth.perm.cap;
                     st_nxt.ready          = 1'b0;
                     st_nxt.fsm            = ST_SWAP_WAIT;
                  end
               end
            end
         end
         ST_SWAP_WAIT:
         begin
            // Holding off new requests keeps the saved permission tied to its swap
            if (swap_ld_valid_i)
            begin
               // [R15] loaded tag cleared without permission
               st_nxt.dest_valid = 1'b1;
               st_nxt.dest_tag   = swap_ld_tag_i && st_r.swap_cap_perm;
               st_nxt.ready      = 1'b1;
               st_nxt.fsm        = ST_IDLE;
            end
         end
         default:
         begin
            st_nxt.fsm   = ST_IDLE;
            st_nxt.ready = 1'b0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         st_r <= '0;
      else if (ce_i)
         st_r <= st_nxt;
   end

   assign req_ready_o      = st_r.ready;
   assign resp_o           = st_r.resp;
   assign mem_o            = st_r.mem;
   assign pcc_wr_o         = st_r.pcc_wr;
   assign pcc_o            = st_r.pcc;
   assign cap_dest_valid_o = st_r.dest_valid;
   assign cap_dest_tag_o   = st_r.dest_tag;

endmodule : csac_core

// file: csac_core_props.sv
// Concurrent checks on the block ports
`timescale 1ns/1ps
module csac_core_props
(
   input wire logic                 clk_sys_i,
   input wire logic                 arst_n_i,
   input wire logic                 ce_i,
   input wire csac_pkg::csac_cfg_s  cfg_i,
   input wire csac_pkg::csac_req_s  req_i,
   input wire csac_pkg::csac_cap_s  pcc_i,
   input wire logic                 swap_ld_valid_i,
   input wire logic                 req_ready_o,
   input wire csac_pkg::csac_resp_s resp_o,
   input wire csac_pkg::csac_mem_s  mem_o,
   input wire logic                 pcc_wr_o,
   input wire csac_pkg::csac_cap_s  pcc_o,
   input wire logic                 cap_dest_valid_o
);
   // --------------------------------
   // Properties
   // --------------------------------
   wire tk = ce_i && req_i.valid && req_ready_o;
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!arst_n_i);
   sequence s_swap_go;
      tk && req_i.op == csac_pkg::OP_AMOSWAP_C ##1 mem_o.valid && !resp_o.trap;
   endsequence
   sequence s_swap_back;
      !req_ready_o && swap_ld_valid_i;
   endsequence
   a_done_pulse: assert property (tk |=> resp_o.done)
      else $error("request not answered");
   a_tag_first: assert property (tk && req_i.op == csac_pkg::OP_STORE && req_i.cap_mode
      && cfg_i.purecap && req_i.size != csac_pkg::SZ_D && !req_i.cap_base_reg.tag
      |=> resp_o.trap && resp_o.exc_code == csac_pkg::EXC_CAP_FAULT
      && resp_o.tval_type == csac_pkg::TYPE_DATA && resp_o.tval_cause == csac_pkg::CAUSE_TAG)
      else $error("tag fault not reported");
   a_ret_perm: assert property (tk && req_i.op inside {csac_pkg::OP_MRET, csac_pkg::OP_SRET}
      && !pcc_i.perm.sysreg_access_perm
      |=> resp_o.tval_type == csac_pkg::TYPE_INSTR && resp_o.tval_cause == csac_pkg::CAUSE_PERM)
      else $error("return not faulted");
   a_ret_unseal: assert property (tk && req_i.op == csac_pkg::OP_MRET
      && pcc_i.perm.sysreg_access_perm |=> pcc_wr_o && !pcc_o.sealed)
      else $error("pcc not installed");
   a_dret_quiet: assert property (tk && req_i.op == csac_pkg::OP_DRET && cfg_i.sdext
      |=> !resp_o.trap && pcc_wr_o)
      else $error("debug return not clean");
   a_swap_hold: assert property (s_swap_go |-> !req_ready_o)
      else $error("ready high in swap");
   a_swap_back: assert property (s_swap_back |=> cap_dest_valid_o && req_ready_o)
      else $error("swap not completed");
   a_swap_notag: assert property (tk && req_i.op == csac_pkg::OP_AMOSWAP_C
      && req_i.cap_mode && !req_i.cap_base_reg.perm.cap |=> !mem_o.tag_wr_val)
      else $error("swap tag not cleared");
   a_store_clr: assert property (resp_o.done && !resp_o.trap && mem_o.write
      && !mem_o.read |-> mem_o.valid && mem_o.tag_clr)
      else $error("store tags not cleared");
endmodule : csac_core_props

// file: csac_mem_model.sv
// Memory model answering swaps after a delay
`timescale 1ns/1ps
module csac_mem_model
(
   input  wire logic                clk_sys_i,
   input  wire logic                arst_n_i,
   input  wire csac_pkg::csac_mem_s mem_i,
   input  wire logic [3:0]          delay_i,
   input  wire logic                ld_tag_i,
   output logic                     swap_ld_valid_o,
   output logic                     swap_ld_tag_o
);
   logic [4:0] cnt_r;
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         cnt_r           <= 5'h00;
         swap_ld_valid_o <= 1'b0;
         swap_ld_tag_o   <= 1'b0;
      end
      else
      begin
         swap_ld_valid_o <= cnt_r == 5'h01;
         // Idle tag shows the inverse, so a stale sample fails
         swap_ld_tag_o   <= (cnt_r == 5'h01) ? ld_tag_i : ~ld_tag_i;
         if (mem_i.valid && mem_i.tag_wr)
            cnt_r <= {1'b0, delay_i} + 5'h01;
         else if (cnt_r != 5'h00)
            cnt_r <= cnt_r - 5'h01;
      end
   end
endmodule : csac_mem_model

// file: csac_core_test.sv
// Directed bench for the capability checks
`timescale 1ns/1ps
module csac_core_test;
   // --------------------------------
   // Bench signals and tasks
   // --------------------------------
   logic                 clk, arst_n, ce, ldv, ldt, ldtag, rdy, pcwr, cdv, cdt;
   logic [3:0]           dly;
   csac_pkg::csac_cfg_s  cfg;
   csac_pkg::csac_req_s  req;
   csac_pkg::csac_cap_s  ddc, pcc, mepcc, sepcc, dpcc, pcco, pc;
   csac_pkg::csac_resp_s resp, rs;
   csac_pkg::csac_mem_s  mem, ms;
   int                   error_cnt, num_checks;
   localparam csac_pkg::csac_size_e B = csac_pkg::SZ_B, H = csac_pkg::SZ_H;
   localparam csac_pkg::csac_size_e W = csac_pkg::SZ_W, D = csac_pkg::SZ_D;
   localparam csac_pkg::csac_op_e ST = csac_pkg::OP_STORE, AM = csac_pkg::OP_AMO;
   localparam csac_pkg::csac_op_e LR = csac_pkg::OP_LR, SWP = csac_pkg::OP_AMOSWAP_C;

   csac_core dut
   (
      .clk_sys_i(clk), .arst_n_i(arst_n), .ce_i(ce), .cfg_i(cfg), .req_i(req),
      .ddc_i(ddc), .pcc_i(pcc), .mepcc_i(mepcc), .sepcc_i(sepcc), .dpcc_i(dpcc),
      .swap_ld_valid_i(ldv), .swap_ld_tag_i(ldt), .req_ready_o(rdy), .resp_o(resp),
      .mem_o(mem), .pcc_wr_o(pcwr), .pcc_o(pcco), .cap_dest_valid_o(cdv),
      .cap_dest_tag_o(cdt)
   );
   csac_mem_model u_mem
   (
      .clk_sys_i(clk), .arst_n_i(arst_n), .mem_i(mem), .delay_i(dly), .ld_tag_i(ldtag),
      .swap_ld_valid_o(ldv), .swap_ld_tag_o(ldt)
   );

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task final_report;
      if (error_cnt == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : final_report

   task automatic chk(input string nm, input logic [159:0] e, input logic [159:0] g);
      num_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask : chk

   function automatic csac_pkg::csac_cap_s mk(input logic [6:0] f, input logic [15:0] a);
      mk = '{f[6], f[5], f[4:0], 64'h1000, 65'h2000, {48'h0, a}};
   endfunction : mk

   function automatic logic [13:0] cf(input logic [4:0] c);
      cf = {csac_pkg::EXC_CAP_FAULT, csac_pkg::TYPE_DATA, c};
   endfunction : cf
   // One request, response checked next cycle
   task automatic rq(input csac_pkg::csac_op_e op, input csac_pkg::csac_size_e sz,
                     input logic md, input csac_pkg::csac_cap_s c, input logic [11:0] off,
                     input logic [13:0] f);
      int n = 0;
      req <= '{1'b1, op, sz, md, 64'h2000, c, off, 64'h1122_3344_5566_7788, 1'b1};
      do
      begin
         @(posedge clk);
         n++;
      end
      while (rdy !== 1'b1 && n < 40);
      req.valid <= 1'b0;
      @(posedge clk);
      rs = resp;
      ms = mem;
      pc = pcco;
      if (n >= 40)
      begin
         error_cnt++;
         $display("mismatch ready exp 1 got 0");
         final_report();
      end
      chk("resp", {1'b1, f != 14'h0, f},
          {rs.done, rs.trap, rs.exc_code, rs.tval_type, rs.tval_cause});
   endtask : rq
   // Bounded wait for swap result
   task automatic wt(input logic e);
      int k = 0;
      while (cdv !== 1'b1 && k < 20)
      begin
         @(posedge clk);
         k++;
      end
      chk("cdest", {1'b1, e}, {cdv, cdt});
   endtask : wt

   initial
   begin
      logic [6:0] fl [4];
      logic [4:0] cs [4];
      int         k;
      fl = '{7'h1f, 7'h7f, 7'h57, 7'h3f};
      cs = '{5'h01, 5'h02, 5'h03, 5'h01};
      arst_n = 1'b0;
      ce = 1'b1;
      cfg = 7'h7f;
      req = '0;
      dly = 4'h0;
      ldtag = 1'b0;
      ddc = mk(7'h5f, 16'h0);
      pcc = mk(7'h5f, 16'h0);
      mepcc = mk(7'h7f, 16'h1234);
      sepcc = mk(7'h7f, 16'h1238);
      dpcc = mk(7'h7f, 16'h5678);
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      rq(ST, D, 1, mk(7'h5f, 16'h1010), 12'hffc, 0);
      chk("st", {64'h100c, 8'hf0, 64'h1000, 2'b11},
          {ms.addr, ms.be, ms.tag_clr_addr, ms.tag_clr, ms.tag_clr_two});
      rq(ST, B, 0, mk(7'h00, 16'h0), 12'h800, 0);
      chk("st", {64'h1800, 8'h01, 1'b0}, {ms.addr, ms.be, ms.tag_clr_two});
      for (k = 0; k < 4; k++)
         rq(ST, W, 1, mk(fl[k], 16'h1100), 0, cf(cs[k]));
      rq(ST, D, 1, mk(7'h5f, 16'h1ffc), 0, cf(5'h04));
      cfg <= 7'h3f;
      rq(ST, D, 1, mk(7'h5f, 16'h1100), 0, 14'h0400);
      cfg <= 7'h5f;
      rq(ST, W, 1, mk(7'h5f, 16'h1100), 0, 14'h0400);
      cfg <= 7'h7f;
      rq(AM, W, 1, mk(7'h4f, 16'h1100), 0, cf(5'h03));
      rq(AM, D, 1, mk(7'h57, 16'h1100), 0, cf(5'h03));
      rq(AM, W, 1, mk(7'h5f, 16'h2000), 0, cf(5'h04));
      rq(AM, W, 1, mk(7'h5f, 16'h1102), 0, 14'h0c00);
      cfg <= 7'h7b;
      rq(AM, W, 1, mk(7'h5f, 16'h1102), 0, 14'h0e00);
      rq(LR, H, 1, mk(7'h5f, 16'h1101), 0, 14'h0a00);
      cfg <= 7'h7f;
      rq(LR, H, 1, mk(7'h5f, 16'h1101), 0, 14'h0800);
      rq(LR, W, 1, mk(7'h4f, 16'h1100), 0, cf(5'h03));
      rq(LR, W, 0, mk(7'h00, 16'h0), 0, cf(5'h04));
      cfg <= 7'h7d;
      rq(LR, B, 1, mk(7'h5f, 16'h1100), 0, 14'h0400);
      cfg <= 7'h3f;
      rq(LR, D, 1, mk(7'h5f, 16'h1100), 0, 14'h0400);
      cfg <= 7'h7f;
      ldtag <= 1'b1;
      dly <= 4'h3;
      rq(SWP, D, 1, mk(7'h5b, 16'h1010), 0, 0);
      chk("tagwr", 2'b10, {ms.tag_wr, ms.tag_wr_val});
      wt(1'b0);
      dly <= 4'h0;
      rq(SWP, D, 1, mk(7'h5f, 16'h1020), 0, 0);
      chk("tagwr", 2'b11, {ms.tag_wr, ms.tag_wr_val});
      wt(1'b1);
      for (k = 0; k < 3; k++)
         rq(SWP, D, 1, mk(fl[k], 16'h1020), 0, cf(cs[k]));
      rq(SWP, D, 1, mk(7'h5f, 16'h2000), 0, cf(5'h04));
      rq(csac_pkg::OP_MRET, W, 0, pcc, 0, 0);
      chk("pcc", {1'b0, 64'h1234}, {pc.sealed, pc.addr});
      rq(csac_pkg::OP_SRET, W, 0, pcc, 0, 0);
      chk("pcc", {1'b0, 64'h1238}, {pc.sealed, pc.addr});
      pcc <= mk(7'h5d, 16'h0);
      rq(csac_pkg::OP_MRET, W, 0, pcc, 0, 14'h3823);
      rq(csac_pkg::OP_SRET, W, 0, pcc, 0, 14'h3823);
      rq(csac_pkg::OP_DRET, W, 0, pcc, 0, 0);
      chk("pcc", {1'b0, 64'h5678}, {pc.sealed, pc.addr});
      final_report();
   end
endmodule : csac_core_test

bind csac_core csac_core_props u_props (.clk_sys_i, .arst_n_i, .ce_i, .cfg_i, .req_i,
   .pcc_i, .swap_ld_valid_i, .req_ready_o, .resp_o, .mem_o, .pcc_wr_o, .pcc_o,
   .cap_dest_valid_o);
